// ### design/pos_status_params.svh
// object indices, field positions, reset values and timing counts
`ifndef POS_STATUS_PARAMS_SVH
`define POS_STATUS_PARAMS_SVH

`define IDX_STATE_WORD      16'h6041
`define IDX_POS_THRESHOLD   16'h6067
`define IDX_POS_SETTLE      16'h6068

`define SW_IN_POS_BIT       10
`define SW_MODE_BIT         12
`define SW_FOLLOW_ERR_BIT   13
`define SW_RSVD_HI          15
`define SW_RSVD_LO          14

`define POS_THRESHOLD_RST   32'h0000_0000
`define POS_SETTLE_RST      16'h0000

`define MS_STEP_NS          1000000
`define MCLK_PERIOD_NS      100
`define CYC_PER_MS          (`MS_STEP_NS / `MCLK_PERIOD_NS)

`endif

// ### design/pos_status_pkg.sv
// types shared by the in-position status logic
package pos_status_pkg;

	typedef struct packed {
		logic op_enabled;
		logic setpoints_released;
		logic gen_done;
		logic halt_req;
		logic axis_at_rest;
	} motion_state_t;

	typedef struct packed {
		logic        wr;
		logic [15:0] index;
		logic [31:0] wdata;
	} obj_write_t;

	typedef struct packed {
		logic [31:0] data;
		logic        hit;
	} obj_read_t;

endpackage

// ### design/position_reached_status.sv
// in-position and following-error bits of the drive state word
`timescale 1ns/1ps
`include "pos_status_params.svh"

module position_reached_status
	import pos_status_pkg::*;
#(
	parameter int unsigned CYC_PER_MS = `CYC_PER_MS
) (
	input  wire logic          MCLK,
	input  wire logic          SYS_RST,
	input  wire motion_state_t MOTION,
	input  wire logic [31:0]   DEMAND_POS,
	input  wire logic [31:0]   ACTUAL_POS,
	input  wire logic [31:0]   FOLLOW_ERR_WINDOW,
	input  wire logic [15:0]   FOLLOW_ERR_TIMEOUT_MS,
	input  wire logic          MODE_SPEC_BIT12,
	input  wire logic [15:0]   OTHER_STATE_BITS,
	input  wire obj_write_t    OBJ_WR,
	input  wire logic [15:0]   OBJ_RD_INDEX,
	output obj_read_t          OBJ_RD,
	output logic [15:0]        STATE_WORD
);

	logic [31:0] threshold_r;
	logic [31:0] threshold_nxt;
	logic [15:0] settle_r;
	logic [15:0] settle_nxt;
	logic [15:0] word_r;
	logic [15:0] word_nxt;
	obj_read_t   rd_r;
	obj_read_t   rd_nxt;

	logic [32:0] dev;
	logic [32:0] dev_mag;
	logic [32:0] fe_mag;
	logic        in_win;
	logic        fe_out;
	logic        settled;
	logic        fe_timed_out;
	logic        pos_done;
	logic        in_pos;

	// signed deviation, one bit wider so no wrap
	always_comb begin
		dev     = {DEMAND_POS[31], DEMAND_POS} - {ACTUAL_POS[31], ACTUAL_POS};
		dev_mag = dev[32] ? (33'h0 - dev) : dev;
		fe_mag  = dev_mag;
		in_win  = dev_mag <= {1'b0, threshold_r};
		fe_out  = fe_mag > {1'b0, FOLLOW_ERR_WINDOW};
	end

	settle_timer #(
		.CYC_PER_MS (CYC_PER_MS)
	) u_settle (
		.clk      (MCLK),
		.rst      (SYS_RST),
		.cond     (in_win),
		.limit_ms (settle_r),
		.done     (settled)
	);

	settle_timer #(
		.CYC_PER_MS (CYC_PER_MS)
	) u_follow (
		.clk      (MCLK),
		.rst      (SYS_RST),
		.cond     (fe_out),
		.limit_ms (FOLLOW_ERR_TIMEOUT_MS),
		.done     (fe_timed_out)
	);

	// flag meaning switches with the halt request
	always_comb begin
		pos_done = MOTION.op_enabled && MOTION.setpoints_released &&
			MOTION.gen_done && settled && in_win;
		if (MOTION.halt_req) begin
			in_pos = MOTION.axis_at_rest;
		end else begin
			in_pos = pos_done;
		end
	end

	// state word assembly
	always_comb begin
		word_nxt = OTHER_STATE_BITS;
		word_nxt[`SW_IN_POS_BIT]     = in_pos;
		word_nxt[`SW_MODE_BIT]       = MODE_SPEC_BIT12;
		word_nxt[`SW_FOLLOW_ERR_BIT] = fe_timed_out;
		word_nxt[`SW_RSVD_HI]        = 1'b0;
		word_nxt[`SW_RSVD_LO]        = 1'b0;
	end

	// object writes; the state word itself is read only
	always_comb begin
		threshold_nxt = threshold_r;
		settle_nxt    = settle_r;
		if (OBJ_WR.wr) begin
			if (OBJ_WR.index == `IDX_POS_THRESHOLD) begin
				threshold_nxt = OBJ_WR.wdata;
			end
			if (OBJ_WR.index == `IDX_POS_SETTLE) begin
				settle_nxt = OBJ_WR.wdata[15:0];
			end
		end
	end

	// object reads; unmapped index returns zero with no hit
	always_comb begin
		rd_nxt.data = 32'h0000_0000;
		rd_nxt.hit  = 1'b1;
		unique case (OBJ_RD_INDEX)
			`IDX_STATE_WORD: begin
				rd_nxt.data = {16'h0000, word_r};
			end
			`IDX_POS_THRESHOLD: begin
				rd_nxt.data = threshold_r;
			end
			`IDX_POS_SETTLE: begin
				rd_nxt.data = {16'h0000, settle_r};
			end
			default: begin
				rd_nxt.hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			threshold_r <= `POS_THRESHOLD_RST;
			settle_r    <= `POS_SETTLE_RST;
			word_r      <= 16'h0000;
			rd_r        <= '0;
		end else begin
			threshold_r <= threshold_nxt;
			settle_r    <= settle_nxt;
			word_r      <= word_nxt;
			rd_r        <= rd_nxt;
		end
	end

	assign STATE_WORD = word_r;
	assign OBJ_RD     = rd_r;

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (SYS_RST);

	chk_reserved_zero: assert property (
		STATE_WORD[15:14] == 2'b00)
		else $error("reserved state bits not zero");

	chk_halt_decel: assert property (
		MOTION.halt_req && !MOTION.axis_at_rest |=> !STATE_WORD[10])
		else $error("in-position set while decelerating under halt");

	chk_halt_rest: assert property (
		MOTION.halt_req && MOTION.axis_at_rest |=> STATE_WORD[10])
		else $error("in-position clear with axis at rest under halt");

	chk_not_enabled: assert property (
		!MOTION.halt_req && !(MOTION.op_enabled &&
		MOTION.setpoints_released && MOTION.gen_done) |=> !STATE_WORD[10])
		else $error("in-position set without enabled finished motion");

	chk_unfinished: assert property (
		!MOTION.halt_req && !settled |=> !STATE_WORD[10])
		else $error("in-position set before settle time elapsed");

	chk_pos_done: assert property (
		!MOTION.halt_req && MOTION.op_enabled && MOTION.setpoints_released
		&& MOTION.gen_done && settled && in_win |=> STATE_WORD[10])
		else $error("in-position clear after positioning completed");

	chk_out_window: assert property (
		!MOTION.halt_req && !in_win |=> !STATE_WORD[10] && !settled)
		else $error("in-position held after leaving the window");

	chk_window_write: assert property (
		OBJ_WR.wr && OBJ_WR.index == `IDX_POS_THRESHOLD
		|=> threshold_r == $past(OBJ_WR.wdata))
		else $error("threshold write not stored");

	chk_settle_write: assert property (
		OBJ_WR.wr && OBJ_WR.index == `IDX_POS_SETTLE
		|=> settle_r == $past(OBJ_WR.wdata[15:0]))
		else $error("settle time write not stored");

	chk_word_read: assert property (
		OBJ_RD_INDEX == `IDX_STATE_WORD
		|=> OBJ_RD.hit && OBJ_RD.data == {16'h0000, $past(STATE_WORD)})
		else $error("state word read not returned");

	chk_mode_bit: assert property (
		##1 STATE_WORD[12] == $past(MODE_SPEC_BIT12))
		else $error("mode-specific bit 12 not passed through");

	chk_follow_flag: assert property (
		fe_timed_out |=> STATE_WORD[13])
		else $error("following error not reported");

	chk_follow_clear: assert property (
		!fe_timed_out |=> !STATE_WORD[13])
		else $error("following error reported without timeout");

	cov_settled: cover property (
		!MOTION.halt_req && $rose(STATE_WORD[10]));
	cov_halt_stop: cover property (
		MOTION.halt_req ##1 $rose(STATE_WORD[10]));
	cov_follow_err: cover property ($rose(STATE_WORD[13]));
	cov_leave_win: cover property (
		STATE_WORD[10] && !in_win && !MOTION.halt_req);

endmodule // position_reached_status

// ### design/settle_timer.sv
// millisecond qualification timer, restarted whenever its condition drops
`timescale 1ns/1ps
module settle_timer #(
	parameter int unsigned CYC_PER_MS = 10000
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        cond,
	input  wire logic [15:0] limit_ms,
	output logic             done
);
	localparam int unsigned PW = $clog2(CYC_PER_MS + 1);
	localparam logic [PW-1:0] PRE_LAST = PW'(CYC_PER_MS - 1);

	logic [PW-1:0] pre_r;
	logic [PW-1:0] pre_nxt;
	logic [15:0]   ms_r;
	logic [15:0]   ms_nxt;
	logic          done_r;
	logic          done_nxt;

	// counts whole ms while cond holds; any drop restarts the count
	always_comb begin
		pre_nxt  = '0;
		ms_nxt   = '0;
		done_nxt = 1'b0;
		if (cond) begin
			pre_nxt = pre_r;
			ms_nxt  = ms_r;
			if (ms_r >= limit_ms) begin
				done_nxt = 1'b1;
			end else if (pre_r == PRE_LAST) begin
				pre_nxt = '0;
				ms_nxt  = ms_r + 16'h0001;
			end else begin
				pre_nxt = pre_r + PW'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pre_r  <= '0;
			ms_r   <= 16'h0000;
			done_r <= 1'b0;
		end else begin
			pre_r  <= pre_nxt;
			ms_r   <= ms_nxt;
			done_r <= done_nxt;
		end
	end

	assign done = done_r;

	chk_timer_restart: assert property (@(posedge clk) disable iff (rst)
		!cond |=> !done && ms_r == 16'h0000)
		else $error("timer not restarted after condition dropped");

	chk_settle_elapsed: assert property (@(posedge clk) disable iff (rst)
		$rose(done) |-> $past(ms_r) >= $past(limit_ms) && $past(cond))
		else $error("timer finished before the settle time");

endmodule // settle_timer

// ### test/fieldbus_master_model.sv
// object write and read master facing the in-position status logic
`timescale 1ns/1ps
module fieldbus_master_model
	import pos_status_pkg::*;
(
	input  wire logic      clk,
	output obj_write_t     obj_wr,
	output logic [15:0]    rd_index,
	input  wire obj_read_t obj_rd
);
	initial begin
		obj_wr = '0;
		rd_index = 16'h0000;
	end

	// one-cycle strobe, fields scrambled once the strobe drops
	task automatic wr_obj(input logic [15:0] idx, input logic [31:0] d);
		@(posedge clk);
		obj_wr <= '{1'b1, idx, d};
		@(posedge clk);
		obj_wr <= '{1'b0, ~idx, ~d};
	endtask

	// index taken at the next edge, answer settled just after it
	task automatic rd_obj(input logic [15:0] idx, output obj_read_t r);
		@(posedge clk);
		rd_index <= idx;
		@(posedge clk);
		#1 r = obj_rd;
	endtask
endmodule // fieldbus_master_model

// ### test/position_reached_status_bench.sv
// self-checking bench for the in-position status logic
`timescale 1ns/1ps
module position_reached_status_bench
	import pos_status_pkg::*;
;
	localparam int unsigned C = 4;
	logic          mclk = 1'b0;
	logic          sys_rst = 1'b1;
	motion_state_t motion = '0;
	logic [31:0]   dem = '0;
	logic [31:0]   act = 32'd500;
	logic [31:0]   fe_win = 32'hFFFF_FFFF;
	logic [15:0]   fe_to = 16'h0001;
	logic [15:0]   other = 16'h0000;
	logic          mode12 = 1'b0;
	obj_write_t    obj_wr;
	logic [15:0]   rd_index;
	obj_read_t     obj_rd;
	obj_read_t     r;
	logic [15:0]   sw;
	motion_state_t bad [3];
	int            failures = 0;
	int            samples_checked = 0;

	always #50 mclk = ~mclk;

	position_reached_status #(.CYC_PER_MS(C)) position_reached_status_i (
		.MCLK(mclk), .SYS_RST(sys_rst), .MOTION(motion),
		.DEMAND_POS(dem), .ACTUAL_POS(act), .FOLLOW_ERR_WINDOW(fe_win),
		.FOLLOW_ERR_TIMEOUT_MS(fe_to), .MODE_SPEC_BIT12(mode12),
		.OTHER_STATE_BITS(other), .OBJ_WR(obj_wr),
		.OBJ_RD_INDEX(rd_index), .OBJ_RD(obj_rd), .STATE_WORD(sw)
	);

	fieldbus_master_model fieldbus_master_model_i (
		.clk(mclk), .obj_wr(obj_wr), .rd_index(rd_index), .obj_rd(obj_rd)
	);

	task automatic give_verdict;
		if (failures == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t word %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_obj(input obj_read_t got, input logic [31:0] d,
		input logic h);
		samples_checked++;
		if (got !== {d, h}) begin
			failures++;
			$display("[ERR] %0t read %h expected %h", $time, got, {d, h});
		end
	endtask

	task automatic drive(input motion_state_t m, input logic [31:0] d,
		input logic [31:0] a);
		@(posedge mclk);
		motion <= m;
		dem <= d;
		act <= a;
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	initial begin
		repeat (2000) @(posedge mclk);
		failures++;
		give_verdict;
	end

	initial begin
		bad = '{5'b01100, 5'b10100, 5'b11000};
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		settle(1);
		chk_word(sw, 16'h0000);
		fieldbus_master_model_i.wr_obj(16'h6067, 32'h0000_000A);
		fieldbus_master_model_i.wr_obj(16'h6068, 32'hABCD_0002);
		fieldbus_master_model_i.wr_obj(16'h6041, 32'h0000_FFFF);
		fieldbus_master_model_i.rd_obj(16'h6068, r);
		chk_obj(r, 32'h0000_0002, 1'b1);
		fieldbus_master_model_i.rd_obj(16'h6067, r);
		chk_obj(r, 32'h0000_000A, 1'b1);
		fieldbus_master_model_i.rd_obj(16'h1234, r);
		chk_obj(r, 32'h0000_0000, 1'b0);
		// deviation of -10 sits on the window edge
		drive(5'b11100, 32'd90, 32'd100);
		settle(9);
		chk_word({15'h0000, sw[10]}, 16'h0000);
		settle(1);
		chk_word({15'h0000, sw[10]}, 16'h0001);
		drive(5'b11100, 32'd100, 32'd111);
		settle(2);
		chk_word({15'h0000, sw[10]}, 16'h0000);
		drive(5'b11100, 32'd110, 32'd100);
		settle(8);
		chk_word({15'h0000, sw[10]}, 16'h0000);
		settle(4);
		chk_word({15'h0000, sw[10]}, 16'h0001);
		for (int i = 0; i < 3; i++) begin
			drive(bad[i], 32'd100, 32'd100);
			settle(12);
			chk_word({15'h0000, sw[10]}, 16'h0000);
		end
		drive(5'b00010, 32'd0, 32'd500);
		settle(3);
		chk_word({15'h0000, sw[10]}, 16'h0000);
		drive(5'b00011, 32'd0, 32'd500);
		settle(3);
		chk_word({15'h0000, sw[10]}, 16'h0001);
		fieldbus_master_model_i.rd_obj(16'h6041, r);
		chk_obj(r, 32'h0000_0400, 1'b1);
		// deviation 20 against a following-error window of 5
		drive(5'b11100, 32'd120, 32'd100);
		fe_win <= 32'd5;
		settle(5);
		chk_word({15'h0000, sw[13]}, 16'h0000);
		settle(1);
		chk_word({15'h0000, sw[13]}, 16'h0001);
		drive(5'b11100, 32'd100, 32'd100);
		settle(3);
		chk_word({15'h0000, sw[13]}, 16'h0000);
		@(posedge mclk);
		other <= 16'hFFFF;
		mode12 <= 1'b1;
		settle(2);
		chk_word(sw & 16'hDBFF, 16'h1BFF);
		@(posedge mclk);
		mode12 <= 1'b0;
		settle(2);
		chk_word(sw & 16'hDBFF, 16'h0BFF);
		give_verdict;
	end
endmodule // position_reached_status_bench
